// file: vep_pkg.sv
// Constants, encodings and state types for the voltage estimation and protection block.
`default_nettype none

package vep_pkg;

    localparam int CLK_PERIOD_NS        = 100;
    localparam int OP_CYCLE_NS          = 9823000;
    localparam int OP_CYCLE_CLKS        = OP_CYCLE_NS / CLK_PERIOD_NS;
    localparam int SAMPLES_PER_CYCLE    = 64;
    localparam int OVP_BLANK_DIV        = 4;
    localparam int OSC_REFRESH_CYCLES   = 7;
    localparam int RESTART_CYCLES       = 2;
    localparam int STARTUP_CYCLES_PER_CAP = 8;
    localparam int HIST_DEPTH           = 64;
    localparam int RMS_NUM              = 707;
    localparam int RMS_DEN              = 1000;
    localparam int DIODE_DROP_MV        = 700;
    localparam int FILT_SHIFT           = 2;

    localparam logic [7:0]  LIM_A_LO = 8'h22;
    localparam logic [7:0]  LIM_B_LO = 8'h25;
    localparam logic [7:0]  LIM_C_LO = 8'h37;
    localparam logic [7:0]  LIM_D_LO = 8'h49;
    localparam logic [15:0] OCP2_A_MV = 16'h0258;
    localparam logic [15:0] OCP2_B_MV = 16'h0320;
    localparam logic [15:0] OCP2_C_MV = 16'h04B0;
    localparam logic [15:0] OCP2_D_MV = 16'h0640;

    localparam logic [15:0] RESET_VOLT  = 16'h0000;
    localparam logic [11:0] RESET_OSC   = 12'h000;

    typedef enum logic [2:0] {
        VEP_ERR_NONE  = 3'b000,
        VEP_ERR_OCP   = 3'b001,
        VEP_ERR_UVP   = 3'b010,
        VEP_ERR_SUVP  = 3'b011,
        VEP_ERR_OVP   = 3'b100
    } vep_err_t;

    typedef enum logic [1:0] {
        VEP_ST_OFF    = 2'b00,
        VEP_ST_START  = 2'b01,
        VEP_ST_REG    = 2'b10,
        VEP_ST_LATCH  = 2'b11
    } vep_state_t;

endpackage : vep_pkg

`default_nettype wire

// file: vep_blank_timer.sv
// Blanking timer that flags a condition held longer than a programmable count.
`default_nettype none

module vep_blank_timer #(
    parameter int W = 20
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         cond,
    input  wire logic [W-1:0] limit,
    output logic              expired
);

    logic [W-1:0] count;
    logic [W-1:0] next_count;

    always_comb begin
        next_count = '0;
        if (cond && count != {W{1'b1}}) begin
            next_count = count + 1'b1;
        end else if (cond) begin
            next_count = count;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // The count holds the cycles already seen, so a trip needs limit plus one held cycles.
    assign expired = cond && (count >= limit);

    chk_timer_restart : assert property (@(posedge clk) disable iff (rst) !cond |=> (count == '0))
        else $error("blanking count not cleared after condition dropped");

endmodule : vep_blank_timer

`default_nettype wire

// file: vep_voltage_protect.sv
// Output and input voltage estimation with output and overcurrent protections.
`default_nettype none

module vep_voltage_protect #(
    parameter int OP_CYCLE_CLKS = vep_pkg::OP_CYCLE_CLKS
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        gate_on,
    input  wire logic        aux_cross_pin,
    input  wire logic [11:0] aux_adc,
    input  wire logic [11:0] clamp_current,
    input  wire logic [11:0] cs_adc,
    input  wire logic        valley_switch_mode,
    input  wire logic        discontinuous_mode,
    input  wire logic        burst_mode,
    input  wire logic        line_sync_ok,
    input  wire logic        line_cycle_pulse,
    input  wire logic [7:0]  divider_upper_resistor,
    input  wire logic [7:0]  divider_lower_resistor,
    input  wire logic [7:0]  sec_turns,
    input  wire logic [7:0]  pri_turns,
    input  wire logic [7:0]  aux_turns,
    input  wire logic [11:0] negative_clamp_level,
    input  wire logic [7:0]  ripple_resistor,
    input  wire logic [7:0]  shunt_resistor,
    input  wire logic [5:0]  zero_cross_delay_trim,
    input  wire logic [7:0]  low_line_current_limit,
    input  wire logic [19:0] overcurrent_blank_time,
    input  wire logic        output_undervolt_enable,
    input  wire logic [15:0] output_undervolt_level,
    input  wire logic [19:0] output_undervolt_blank_time,
    input  wire logic        output_undervolt_reaction,
    input  wire logic [15:0] output_overvolt_level,
    input  wire logic        output_overvolt_reaction,
    input  wire logic [15:0] startup_output_level,
    input  wire logic [3:0]  supply_cap_setting,
    output logic             gate_enable,
    output logic             startup_phase,
    output logic             regulated_phase,
    output logic             latched_off,
    output logic [15:0]      est_output_voltage,
    output logic [15:0]      est_input_peak,
    output logic [15:0]      est_input_rms,
    output logic [11:0]      ringing_period,
    output logic [15:0]      overcurrent_level_two,
    output logic [2:0]       error_code,
    output logic             protection_event
);

    localparam logic [16:0] CYC_LAST = 17'(OP_CYCLE_CLKS - 1);
    localparam logic [16:0] SUB_LAST = 17'(OP_CYCLE_CLKS / vep_pkg::SAMPLES_PER_CYCLE - 1);
    localparam logic [19:0] OVP_CLKS = 20'(OP_CYCLE_CLKS / vep_pkg::OVP_BLANK_DIV);

    function automatic logic [15:0] sat16(input logic signed [31:0] x);
        if (x < 0) begin
            sat16 = 16'h0000;
        end else if (x > 32'sd65535) begin
            sat16 = 16'hFFFF;
        end else begin
            sat16 = x[15:0];
        end
    endfunction : sat16

    function automatic logic [15:0] ocp2_sel(input logic [7:0] lim);
        if (lim >= vep_pkg::LIM_D_LO) begin
            ocp2_sel = vep_pkg::OCP2_D_MV;
        end else if (lim >= vep_pkg::LIM_C_LO) begin
            ocp2_sel = vep_pkg::OCP2_C_MV;
        end else if (lim >= vep_pkg::LIM_B_LO) begin
            ocp2_sel = vep_pkg::OCP2_B_MV;
        end else begin
            ocp2_sel = vep_pkg::OCP2_A_MV;
        end
    endfunction : ocp2_sel

    // Cycle timing: free-running default period unless line sync supplies the boundary.
    logic [16:0] cyc_cnt, next_cyc_cnt, sub_cnt, next_sub_cnt;
    logic        cycle_end, sub_tick;

    assign cycle_end = line_sync_ok ? line_cycle_pulse : (cyc_cnt == CYC_LAST);
    assign sub_tick  = (sub_cnt == SUB_LAST);

    always_comb begin
        next_cyc_cnt = (cycle_end || cyc_cnt == CYC_LAST) ? 17'h00000 : cyc_cnt + 17'h00001;
        next_sub_cnt = (sub_tick || cycle_end) ? 17'h00000 : sub_cnt + 17'h00001;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cyc_cnt <= 17'h00000;
            sub_cnt <= 17'h00000;
        end else begin
            cyc_cnt <= next_cyc_cnt;
            sub_cnt <= next_sub_cnt;
        end
    end

    // The comparator output is asynchronous to clk; only the second and third stages feed logic.
    logic cross_s1, cross_s2, cross_s3, cross_edge, gate_prev, gate_fall;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cross_s1  <= 1'b0;
            cross_s2  <= 1'b0;
            cross_s3  <= 1'b0;
            gate_prev <= 1'b0;
        end else begin
            cross_s1  <= aux_cross_pin;
            cross_s2  <= cross_s1;
            cross_s3  <= cross_s2;
            gate_prev <= gate_on;
        end
    end

    assign cross_edge = cross_s2 && !cross_s3;
    assign gate_fall  = gate_prev && !gate_on;

    // A short history of the aux voltage lets the sample be picked from before the crossing.
    logic [11:0] hist [vep_pkg::HIST_DEPTH];
    logic [5:0]  wr_ptr;
    logic [6:0]  lookback;
    logic [11:0] aux_pick;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_ptr <= 6'h00;
        end else begin
            wr_ptr <= wr_ptr + 6'h01;
        end
    end

    always_ff @(posedge clk) begin
        hist[wr_ptr] <= aux_adc;
    end

    always_comb begin
        lookback = 7'(ringing_period[11:2]) + {1'b0, zero_cross_delay_trim};
        if (ringing_period[11:2] > 10'h03F || lookback > 7'h3F) begin
            lookback = 7'h3F;
        end
        // The write pointer addresses the oldest entry, so a lookback of zero means the newest sample.
        aux_pick = hist[wr_ptr - 6'h01 - lookback[5:0]];
    end

    // Sampling armed once per sub-interval (64 per operation cycle) and ringing measurement refreshed every 7 regulated cycles.
    logic        out_arm, next_out_arm, in_arm, next_in_arm;
    logic        wait_cross, next_wait_cross, osc_run, next_osc_run;
    logic        meas_pend, next_meas_pend;
    logic [10:0] osc_cnt, next_osc_cnt;
    logic [11:0] next_ringing;
    logic [2:0]  reg_cyc, next_reg_cyc;
    logic        out_take, in_take;
    vep_pkg::vep_state_t state, next_state;

    assign out_take = wait_cross && cross_edge && out_arm && (valley_switch_mode || discontinuous_mode);
    assign in_take  = gate_fall && in_arm && gate_enable;

    always_comb begin
        next_out_arm    = (out_arm && !out_take) || sub_tick;
        next_in_arm     = (in_arm && !in_take) || sub_tick;
        next_wait_cross = gate_fall ? 1'b1 : (wait_cross && !cross_edge);
        next_osc_run    = osc_run;
        next_osc_cnt    = osc_run ? osc_cnt + 11'h001 : 11'h000;
        next_ringing    = ringing_period;
        next_meas_pend  = meas_pend;
        next_reg_cyc    = reg_cyc;
        if (wait_cross && cross_edge && meas_pend) begin
            next_osc_run = 1'b1;
        end else if (osc_run && cross_edge) begin
            // The count starts one cycle after the first crossing, so one cycle is added back.
            next_ringing   = {1'b0, osc_cnt} + 12'h001;
            next_osc_run   = 1'b0;
            next_meas_pend = 1'b0;
        end
        if (cycle_end && state == vep_pkg::VEP_ST_REG) begin
            next_reg_cyc = (reg_cyc == 3'(vep_pkg::OSC_REFRESH_CYCLES - 1)) ? 3'h0 : reg_cyc + 3'h1;
            if (reg_cyc == 3'(vep_pkg::OSC_REFRESH_CYCLES - 1)) begin
                next_meas_pend = 1'b1;
            end
        end
        if (state == vep_pkg::VEP_ST_OFF) begin
            next_meas_pend = 1'b1;
            next_reg_cyc   = 3'h0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_arm        <= 1'b0;
            in_arm         <= 1'b0;
            wait_cross     <= 1'b0;
            osc_run        <= 1'b0;
            osc_cnt        <= 11'h000;
            ringing_period <= vep_pkg::RESET_OSC;
            meas_pend      <= 1'b1;
            reg_cyc        <= 3'h0;
        end else begin
            out_arm        <= next_out_arm;
            in_arm         <= next_in_arm;
            wait_cross     <= next_wait_cross;
            osc_run        <= next_osc_run;
            osc_cnt        <= next_osc_cnt;
            ringing_period <= next_ringing;
            meas_pend      <= next_meas_pend;
            reg_cyc        <= next_reg_cyc;
        end
    end

    // Estimation arithmetic; a zero divisor yields zero instead of an undefined quotient.
    logic [15:0] vout_now, vin_now, peak_acc, next_peak_acc, filt, next_filt;
    logic [15:0] next_vout, next_peak, next_rms;

    always_comb begin
        logic [31:0] num;
        logic [31:0] den;
        logic signed [31:0] a;
        logic signed [31:0] b;
        num = 32'(aux_pick) * (32'(divider_upper_resistor) + 32'(divider_lower_resistor)) * 32'(sec_turns);
        den = 32'(divider_lower_resistor) * 32'(aux_turns);
        vout_now = (den == 32'h0) ? 16'h0000 :
                   sat16($signed(num / den) - 32'sd700);
        a = (divider_lower_resistor == 8'h00) ? 32'sd0 :
            $signed(32'(clamp_current)) - $signed(32'(negative_clamp_level) / 32'(divider_lower_resistor));
        a = a * $signed(32'(divider_upper_resistor)) - $signed(32'(negative_clamp_level));
        a = (aux_turns == 8'h00) ? 32'sd0 : (a * $signed(32'(pri_turns))) / $signed(32'(aux_turns));
        b = (shunt_resistor == 8'h00) ? 32'sd0 :
            $signed((32'(ripple_resistor) * 32'(cs_adc)) / 32'(shunt_resistor));
        vin_now = sat16(a + b);
    end

    always_comb begin
        logic [31:0] rms_prod;
        next_vout     = out_take ? vout_now : est_output_voltage;
        next_peak_acc = (in_take && vin_now > peak_acc) ? vin_now : peak_acc;
        next_peak     = est_input_peak;
        next_filt     = filt;
        next_rms      = est_input_rms;
        rms_prod      = 32'(filt) * 32'(vep_pkg::RMS_NUM);
        if (cycle_end && state == vep_pkg::VEP_ST_REG) begin
            next_peak     = next_peak_acc;
            next_filt     = 16'($signed({1'b0, filt}) + ($signed({1'b0, next_peak_acc} - {1'b0, filt})
                            >>> vep_pkg::FILT_SHIFT));
            rms_prod      = 32'(next_filt) * 32'(vep_pkg::RMS_NUM);
            next_rms      = 16'(rms_prod / 32'(vep_pkg::RMS_DEN));
            next_peak_acc = 16'h0000;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            est_output_voltage <= vep_pkg::RESET_VOLT;
            peak_acc           <= vep_pkg::RESET_VOLT;
            est_input_peak     <= vep_pkg::RESET_VOLT;
            filt               <= vep_pkg::RESET_VOLT;
            est_input_rms      <= vep_pkg::RESET_VOLT;
        end else begin
            est_output_voltage <= next_vout;
            peak_acc           <= next_peak_acc;
            est_input_peak     <= next_peak;
            filt               <= next_filt;
            est_input_rms      <= next_rms;
        end
    end

    // Protection conditions and their blanking.
    logic ocp_cond, uvp_cond, ovp_cond, ocp_trip, uvp_trip, ovp_trip, suvp_trip, trip_any, trip_latch;
    logic [7:0] st_cycles, next_st_cycles;
    logic [7:0] start_max;

    assign ocp_cond  = gate_enable && ({4'h0, cs_adc} > overcurrent_level_two);
    assign uvp_cond  = regulated_phase && output_undervolt_enable &&
                       (est_output_voltage < output_undervolt_level);
    assign ovp_cond  = gate_enable && !burst_mode && (est_output_voltage > output_overvolt_level);
    assign start_max = 8'(supply_cap_setting) * 8'(vep_pkg::STARTUP_CYCLES_PER_CAP);
    assign suvp_trip = startup_phase && cycle_end && (st_cycles >= start_max) &&
                       (est_output_voltage < startup_output_level);

    vep_blank_timer #(.W(20)) u_ocp_timer (
        .clk     (clk),
        .rst     (rst),
        .cond    (ocp_cond),
        .limit   (overcurrent_blank_time),
        .expired (ocp_trip)
    );

    vep_blank_timer #(.W(20)) u_uvp_timer (
        .clk     (clk),
        .rst     (rst),
        .cond    (uvp_cond),
        .limit   (output_undervolt_blank_time),
        .expired (uvp_trip)
    );

    vep_blank_timer #(.W(20)) u_ovp_timer (
        .clk     (clk),
        .rst     (rst),
        .cond    (ovp_cond),
        .limit   (OVP_CLKS),
        .expired (ovp_trip)
    );

    assign trip_any   = ocp_trip || uvp_trip || ovp_trip || suvp_trip;
    assign trip_latch = (ovp_trip && output_overvolt_reaction) ||
                        (uvp_trip && output_undervolt_reaction && !ocp_trip);

    logic [2:0] next_err;
    logic [7:0] off_cycles, next_off_cycles;

    always_comb begin
        next_state      = state;
        next_err        = error_code;
        next_st_cycles  = (startup_phase && cycle_end && st_cycles != 8'hFF) ? st_cycles + 8'h01 : st_cycles;
        next_off_cycles = (state == vep_pkg::VEP_ST_OFF && cycle_end) ? off_cycles + 8'h01 : off_cycles;
        case (state)
            vep_pkg::VEP_ST_OFF: begin
                if (off_cycles >= 8'(vep_pkg::RESTART_CYCLES)) begin
                    next_state     = vep_pkg::VEP_ST_START;
                    next_st_cycles = 8'h00;
                end
            end
            vep_pkg::VEP_ST_START: begin
                if (!trip_any && est_output_voltage >= startup_output_level && !meas_pend) begin
                    next_state = vep_pkg::VEP_ST_REG;
                end
            end
            vep_pkg::VEP_ST_REG: begin
                next_state = state;
            end
            vep_pkg::VEP_ST_LATCH: begin
                next_state = state;
            end
            default: begin
                next_state = vep_pkg::VEP_ST_OFF;
            end
        endcase
        if (trip_any && state != vep_pkg::VEP_ST_LATCH && state != vep_pkg::VEP_ST_OFF) begin
            next_state      = trip_latch ? vep_pkg::VEP_ST_LATCH : vep_pkg::VEP_ST_OFF;
            next_off_cycles = 8'h00;
            if (ocp_trip) begin
                next_err = vep_pkg::VEP_ERR_OCP;
            end else if (ovp_trip) begin
                next_err = vep_pkg::VEP_ERR_OVP;
            end else if (uvp_trip) begin
                next_err = vep_pkg::VEP_ERR_UVP;
            end else begin
                next_err = vep_pkg::VEP_ERR_SUVP;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state      <= vep_pkg::VEP_ST_START;
            error_code <= vep_pkg::VEP_ERR_NONE;
            st_cycles  <= 8'h00;
            off_cycles <= 8'h00;
        end else begin
            state      <= next_state;
            error_code <= next_err;
            st_cycles  <= next_st_cycles;
            off_cycles <= next_off_cycles;
        end
    end

    assign gate_enable           = (state == vep_pkg::VEP_ST_START) || (state == vep_pkg::VEP_ST_REG);
    assign startup_phase         = (state == vep_pkg::VEP_ST_START);
    assign regulated_phase       = (state == vep_pkg::VEP_ST_REG);
    assign latched_off           = (state == vep_pkg::VEP_ST_LATCH);
    assign protection_event      = trip_any && gate_enable;
    assign overcurrent_level_two = ocp2_sel(low_line_current_limit);

    chk_ocp_table_mid : assert property (@(posedge clk) disable iff (rst)
        (low_line_current_limit >= 8'h25 && low_line_current_limit <= 8'h36) |-> overcurrent_level_two == 16'h0320)
        else $error("overcurrent level two wrong for middle-low range");
    chk_trip_gate_off : assert property (@(posedge clk) disable iff (rst) protection_event |=> !gate_enable)
        else $error("gate still enabled after a protection trip");
    chk_latch_hold : assert property (@(posedge clk) disable iff (rst) latched_off |=> latched_off && !gate_enable)
        else $error("latched state left or gate enabled");
    chk_ovp_burst : assert property (@(posedge clk) disable iff (rst) burst_mode |-> !ovp_cond)
        else $error("overvoltage evaluated in burst mode");
    chk_err_code : assert property (@(posedge clk) disable iff (rst) (protection_event && ocp_trip)
        |=> error_code == vep_pkg::VEP_ERR_OCP)
        else $error("overcurrent error code not retained");
    chk_rms_update : assert property (@(posedge clk) disable iff (rst)
        $changed(est_input_rms) |-> $past(cycle_end) && $past(regulated_phase))
        else $error("rms input changed outside a regulated cycle end");
    chk_cycle_len : assert property (@(posedge clk) disable iff (rst)
        (!line_sync_ok && cycle_end) |-> cyc_cnt == 17'(OP_CYCLE_CLKS - 1))
        else $error("default operation cycle boundary at wrong count");
    chk_sample_once : assert property (@(posedge clk) disable iff (rst) (out_take && !sub_tick) |=> !out_arm)
        else $error("output sample arm not consumed");
    chk_restart_path : assert property (@(posedge clk) disable iff (rst)
        (state == vep_pkg::VEP_ST_OFF) |=> (state == vep_pkg::VEP_ST_OFF || state == vep_pkg::VEP_ST_START))
        else $error("auto-restart did not go through startup");

endmodule : vep_voltage_protect

`default_nettype wire

// file: vep_stage_model.sv
// Behavioural flyback stage as seen through the auxiliary sense and clamp pins.
`default_nettype none
module vep_stage_model #(
    parameter logic [11:0] AUX_MV = 12'h3E8
) (
    input  wire logic   clk,
    input  wire logic   gate_on,
    output logic        aux_cross_pin = 1'b0,
    output logic [11:0] aux_adc = 12'h000,
    output logic [11:0] clamp_current = 12'h000
);
    timeunit 1ns;
    timeprecision 1ns;
    int off_clks = 0;
    // Three ringing crossings eight clocks apart, then the pin rests low as the swing dies out.
    always @(posedge clk) begin
        off_clks <= gate_on ? 0 : off_clks + 1;
        aux_cross_pin <= #2 !gate_on && off_clks >= 6 && off_clks < 30 && ((off_clks - 6) % 8) < 4;
        aux_adc <= #2 gate_on ? 12'h000 : AUX_MV;
        clamp_current <= #2 gate_on ? 12'h0C8 : 12'h000;
    end
endmodule : vep_stage_model
`default_nettype wire

// file: vep_voltage_protect_bench.sv
// Self-checking bench for the voltage estimation and protection block.
`default_nettype none
module vep_voltage_protect_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int CYC = 640;
    localparam logic [11:0] AUX_MV = 12'h3E8;
    // Clamp current that the stage model drives during the on-time.
    localparam int CLAMP_UA = 200;
    logic clk = 1'b0, rst = 1'b1, gate_on = 1'b0, aux_cross_pin, burst_mode = 1'b0;
    logic valley_switch_mode = 1'b1, discontinuous_mode = 1'b0, line_sync_ok = 1'b0, line_cycle_pulse = 1'b0;
    logic output_undervolt_enable = 1'b0, output_undervolt_reaction = 1'b0, output_overvolt_reaction = 1'b1;
    logic [11:0] aux_adc, clamp_current, cs_adc = 12'h000, negative_clamp_level = 12'h064;
    logic [7:0]  divider_upper_resistor = 8'h0A, divider_lower_resistor = 8'h0A;
    logic [7:0]  sec_turns = 8'h04, pri_turns = 8'h08, aux_turns = 8'h04;
    logic [7:0]  ripple_resistor = 8'h01, shunt_resistor = 8'h01, low_line_current_limit = 8'h22;
    logic [5:0]  zero_cross_delay_trim = 6'h00;
    logic [19:0] overcurrent_blank_time = 20'h00014, output_undervolt_blank_time = 20'h00064;
    logic [15:0] output_undervolt_level = 16'h0000, output_overvolt_level = 16'hFFFF;
    logic [15:0] startup_output_level = 16'h0000;
    logic [3:0]  supply_cap_setting = 4'hF;
    logic        gate_enable, startup_phase, regulated_phase, latched_off, protection_event;
    logic [15:0] est_output_voltage, est_input_peak, est_input_rms, overcurrent_level_two;
    logic [11:0] ringing_period;
    logic [2:0]  error_code;
    logic [7:0]  corner [8] = '{8'h22, 8'h24, 8'h25, 8'h36, 8'h37, 8'h48, 8'h49, 8'h6C};
    int          bad_count = 0, checks = 0, ph = 0;

    vep_stage_model #(.AUX_MV(AUX_MV)) stage (.clk(clk), .gate_on(gate_on), .aux_cross_pin(aux_cross_pin),
        .aux_adc(aux_adc), .clamp_current(clamp_current));
    vep_voltage_protect #(.OP_CYCLE_CLKS(CYC)) uut (.*);

    always #50 clk = ~clk;
    // Simple modulator: five clocks on in every thirty while switching is allowed.
    always @(posedge clk) begin
        ph <= (ph + 1) % 30;
        gate_on <= #1 !rst && gate_enable && ph < 5;
    end

    function automatic logic [15:0] exp_ocp2(logic [7:0] lim);
        if (lim <= 8'h24) return 16'h0258;
        if (lim <= 8'h36) return 16'h0320;
        if (lim <= 8'h48) return 16'h04B0;
        return 16'h0640;
    endfunction : exp_ocp2

    function automatic logic [15:0] exp_peak(int cs);
        int a;
        a = (CLAMP_UA - negative_clamp_level / divider_lower_resistor) * divider_upper_resistor - negative_clamp_level;
        return 16'(a * pri_turns / aux_turns + ripple_resistor * cs / shunt_resistor);
    endfunction : exp_peak

    function automatic logic [15:0] exp_rms(int pk, int k);
        int f;
        f = 0;
        for (int i = 0; i < k; i++) begin
            f = f + ((pk - f) >>> vep_pkg::FILT_SHIFT);
        end
        return 16'(f * vep_pkg::RMS_NUM / vep_pkg::RMS_DEN);
    endfunction : exp_rms

    task automatic cmp_val(string what, logic [15:0] exp, logic [15:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_val

    // Counts settled cycles until a trip shows, giving up after lim cycles.
    task automatic wait_trip(int lim, output int n);
        n = 0;
        while (protection_event !== 1'b1 && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
    endtask : wait_trip

    task automatic print_verdict;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict

    initial begin
        #(100 * 16000);
        bad_count++;
        print_verdict();
    end

    initial begin
        int n;
        void'($urandom(73013));
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 24; i++) begin
            @(posedge clk);
            #1 low_line_current_limit = i < 8 ? corner[i] : 8'h22 + 8'($urandom % 75);
            #1 cmp_val("level two", exp_ocp2(low_line_current_limit), overcurrent_level_two);
        end
        low_line_current_limit = 8'h22;
        cs_adc = 12'h300;
        wait_trip(10, n);
        cmp_val("short overcurrent", 16'd10, 16'(n));
        cs_adc = 12'h000;
        @(posedge clk);
        #1 cs_adc = 12'h300;
        wait_trip(40, n);
        cmp_val("overcurrent delay", 16'h0014, 16'(n));
        @(posedge clk);
        #1 cs_adc = 12'h000;
        cmp_val("gate after trip", 16'h0000, 16'(gate_enable));
        cmp_val("error code", 16'h0001, 16'(error_code));
        n = 0;
        while (gate_enable !== 1'b1 && n < 3 * CYC) begin
            @(posedge clk);
            #1 n++;
        end
        cmp_val("restart phase", 16'h0001, 16'(startup_phase));
        repeat (400) @(posedge clk);
        #1 cmp_val("output estimate", 16'(2 * AUX_MV - 700), est_output_voltage);
        cmp_val("regulated", 16'h0001, 16'(regulated_phase));
        // A reset in mid-run clears the filter, so two regulated cycles give a known rms value.
        @(posedge clk);
        #1 rst = 1'b1;
        repeat (10) @(posedge clk);
        #1 rst = 1'b0;
        cmp_val("reset error code", 16'h0000, 16'(error_code));
        cmp_val("reset phase", 16'h0001, 16'(startup_phase));
        repeat (2 * CYC + 5) @(posedge clk);
        #1 cmp_val("ringing period", 16'd8, 16'(ringing_period));
        cmp_val("input peak", exp_peak(0), est_input_peak);
        cmp_val("input rms", exp_rms(exp_peak(0), 2), est_input_rms);
        output_undervolt_enable = 1'b1;
        output_undervolt_level = 16'h0600;
        wait_trip(200, n);
        cmp_val("undervolt delay", 16'h0064, 16'(n));
        @(posedge clk);
        #1 cmp_val("undervolt code", 16'h0002, 16'(error_code));
        cmp_val("undervolt restart", 16'h0000, 16'(latched_off));
        startup_output_level = 16'h0600;
        supply_cap_setting = 4'h0;
        wait_trip(4 * CYC, n);
        @(posedge clk);
        #1 cmp_val("startup undervolt", 16'h0003, 16'(error_code));
        cmp_val("startup restart", 16'h0000, 16'(latched_off));
        output_undervolt_enable = 1'b0;
        startup_output_level = 16'h0000;
        supply_cap_setting = 4'hF;
        n = 0;
        while (gate_enable !== 1'b1 && n < 3 * CYC) begin
            @(posedge clk);
            #1 n++;
        end
        repeat (400) @(posedge clk);
        #1 cmp_val("regulated again", 16'h0001, 16'(regulated_phase));
        burst_mode = 1'b1;
        output_overvolt_level = 16'h0400;
        wait_trip(200, n);
        cmp_val("burst overvolt", 16'd200, 16'(n));
        burst_mode = 1'b0;
        wait_trip(300, n);
        cmp_val("overvolt delay", 16'(CYC / 4), 16'(n));
        repeat (2 * CYC) @(posedge clk);
        #1 cmp_val("latched", 16'h0001, 16'(latched_off));
        cmp_val("overvolt code", 16'h0004, 16'(error_code));
        print_verdict();
    end
endmodule : vep_voltage_protect_bench
`default_nettype wire
